// *** rtl/mdb_decode_defs.vh ***
// Purpose: constants for the move, branch and boolean opcode decoder
// Assumes: one machine cycle is one ref_clk cycle
// Notes:   grouped opcodes are matched on a prefix (P5 = bits 7:3, P7 = bits 7:1) or, for absolute jump and call, on bits 4:0 (L5)
// Notes on behaviour
// - 0xe8-0xef copy working register to accumulator, one byte, one cycle.
// - 0xe5 loads direct byte to accumulator, two bytes, two cycles.
// - 0xe6-0xe7 load indirect RAM byte to accumulator, one byte, two cycles.
// - 0x74 loads immediate byte to accumulator, two bytes, two cycles.
// - 0xf8-0xff copy accumulator to working register, one byte, two cycles.
// - 0xa8-0xaf direct to register two bytes; 0x85 direct to direct three bytes; three cycles.
// - 0xa6-0xa7 store direct byte to indirect RAM, two bytes, three cycles.
// - 0x90 loads 16-bit constant into data_pointer, three bytes, three cycles.
// - code fetch at acc plus data_pointer 0x93 seven cycles, plus pc 0x83 eight.
// - external read, 8-bit address 0xe2-0xe3 five cycles, data_pointer 0xe0 six.
// - external write, 8-bit address 0xf2-0xf3 four cycles, data_pointer 0xf0 five.
// - 0xc0 push two bytes five cycles; 0xd0 pop two bytes four cycles.
// - 0xd6-0xd7 swap only low nibbles with indirect RAM byte, four cycles.
// - 0x80 relative jump two bytes four cycles; 0x73 indirect jump six cycles.
// - 0x60 zero, 0x70 nonzero accumulator branch; two bytes, three or five cycles.
// - 0x40 carry set, 0x50 carry clear branch; two bytes, two or four cycles.
// - 0x20 bit set, 0x30 clear, 0x10 set-and-clear; three bytes, four or six.
// - compare_branch_unequal 0xb5,0xb4,0xb8-0xbf,0xb6-0xb7; three bytes, four or six.
// - decrement branch: register 0xd8-0xdf 3/5 cycles; direct 0xd5 three bytes 4/6.
// - 0x82 and 0xb0 AND carry with bit or complement, two bytes, two cycles.
// - 0x72 and 0xa0 OR carry with bit or complement, two bytes, two cycles.
// - 0x92 carry to bit three cycles; 0xa2 bit to carry two cycles.
`ifndef MDB_DECODE_DEFS_VH
`define MDB_DECODE_DEFS_VH

// widths, lengths, cycle counts
`define MDB_CYC_W        5
`define MDB_L1           2'h1
`define MDB_L2           2'h2
`define MDB_L3           2'h3
`define MDB_C1           5'h01
`define MDB_C2           5'h02
`define MDB_C3           5'h03
`define MDB_C4           5'h04
`define MDB_C5           5'h05
`define MDB_C6           5'h06
`define MDB_C7           5'h07
`define MDB_C8           5'h08
`define MDB_TAKEN_EXTRA  5'h02

// branch condition kinds
`define MDB_K_NONE       4'h0
`define MDB_K_ALWAYS     4'h1
`define MDB_K_AZ         4'h2
`define MDB_K_ANZ        4'h3
`define MDB_K_C          4'h4
`define MDB_K_NC         4'h5
`define MDB_K_B          4'h6
`define MDB_K_NB         4'h7
`define MDB_K_NE         4'h8
`define MDB_K_DNZ        4'h9

// opcode prefixes, bits 7:3
`define MDB_P5_MOV_A_REG   5'h1d
`define MDB_P5_MOV_REG_A   5'h1f
`define MDB_P5_MOV_REG_DIR 5'h15
`define MDB_P5_MOV_REG_IMM 5'h0f
`define MDB_P5_MOV_DIR_REG 5'h11
`define MDB_P5_XCH_REG     5'h19
`define MDB_P5_CBNE_REG    5'h17
`define MDB_P5_DBNZ_REG    5'h1b
// opcode prefixes, bits 7:1
`define MDB_P7_MOV_A_IND   7'h73
`define MDB_P7_MOV_DIR_IND 7'h43
`define MDB_P7_MOV_IND_A   7'h7b
`define MDB_P7_MOV_IND_DIR 7'h53
`define MDB_P7_MOV_IND_IMM 7'h3b
`define MDB_P7_XRD_IND     7'h71
`define MDB_P7_XWR_IND     7'h79
`define MDB_P7_XCH_IND     7'h63
`define MDB_P7_XNIB        7'h6b
`define MDB_P7_CBNE_IND    7'h5b
// absolute jump and call, bits 4:0
`define MDB_L5_AJMP        5'h01
`define MDB_L5_ACALL       5'h11
// full opcodes
`define MDB_OP_MOV_A_DIR   8'he5
`define MDB_OP_MOV_A_IMM   8'h74
`define MDB_OP_MOV_DIR_A   8'hf5
`define MDB_OP_MOV_DIR_DIR 8'h85
`define MDB_OP_MOV_DIR_IMM 8'h75
`define MDB_OP_MOV_DP_IMM  8'h90
`define MDB_OP_CODE_DP     8'h93
`define MDB_OP_CODE_PC     8'h83
`define MDB_OP_XRD_DP      8'he0
`define MDB_OP_XWR_DP      8'hf0
`define MDB_OP_PUSH        8'hc0
`define MDB_OP_POP         8'hd0
`define MDB_OP_XCH_DIR     8'hc5
`define MDB_OP_LCALL       8'h12
`define MDB_OP_RET         8'h22
`define MDB_OP_RETI        8'h32
`define MDB_OP_LJMP        8'h02
`define MDB_OP_RJMP        8'h80
`define MDB_OP_JMP_IND     8'h73
`define MDB_OP_JZ          8'h60
`define MDB_OP_JNZ         8'h70
`define MDB_OP_JC          8'h40
`define MDB_OP_JNC         8'h50
`define MDB_OP_JB          8'h20
`define MDB_OP_JNB         8'h30
`define MDB_OP_JTC         8'h10
`define MDB_OP_CBNE_DIR    8'hb5
`define MDB_OP_CBNE_IMM    8'hb4
`define MDB_OP_DBNZ_DIR    8'hd5
`define MDB_OP_NOP         8'h00
`define MDB_OP_CLR_C       8'hc3
`define MDB_OP_CLR_BIT     8'hc2
`define MDB_OP_SETB_C      8'hd3
`define MDB_OP_SETB_BIT    8'hd2
`define MDB_OP_CPL_C       8'hb3
`define MDB_OP_CPL_BIT     8'hb2
`define MDB_OP_ANL_C       8'h82
`define MDB_OP_ANL_NC      8'hb0
`define MDB_OP_ORL_C       8'h72
`define MDB_OP_ORL_NC      8'ha0
`define MDB_OP_MOV_C_BIT   8'ha2
`define MDB_OP_MOV_BIT_C   8'h92

`endif

// *** rtl/mdb_cycle_cnt.v ***
// Purpose: machine-cycle down counter that paces one instruction
// Assumes: load only while ready_r is high; load_val is at least one
// Notes:   ready_r rises in the last busy cycle so issues run back to back
module mdb_cycle_cnt #(
  parameter W = 5
) (
  // clock, reset, enable
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         ce,
  // new instruction
  input  wire         load,
  input  wire [W-1:0] load_val,
  // state
  output reg          busy_r,
  output reg          last_r,
  output reg          ready_r
);

  reg  [W-1:0] cnt_r;
  wire         load_one;
  wire         cnt_two;

  assign load_one = (load_val == {{(W-1){1'b0}}, 1'b1});
  assign cnt_two  = (cnt_r == {{(W-2){1'b0}}, 2'b10});

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_r   <= {W{1'b0}};
      busy_r  <= 1'b0;
      last_r  <= 1'b0;
      ready_r <= 1'b1;
    end
    else if (ce)
    begin
      if (load)
      begin
        cnt_r   <= load_val;
        busy_r  <= 1'b1;
        last_r  <= load_one;
        ready_r <= load_one;
      end
      else if (busy_r)
      begin
        if (last_r)
        begin
          cnt_r   <= {W{1'b0}};
          busy_r  <= 1'b0;
          last_r  <= 1'b0;
          ready_r <= 1'b1;
        end
        else
        begin
          cnt_r   <= cnt_r - 1'b1;
          last_r  <= cnt_two;
          ready_r <= cnt_two;
        end
      end
    end
  end

endmodule // mdb_cycle_cnt

// *** rtl/mdb_decode.v ***
// Purpose: decode and cycle timing for move, branch and boolean opcodes
// Assumes: condition inputs come from datapath logic on ref_clk, valid with issue
// Notes:   decode results hold until the next accepted issue;
//          opcodes outside this group decode as one byte, one cycle, unknown
`include "mdb_decode_defs.vh"

module mdb_decode (
  // clock, reset, enable
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  // instruction issue
  input  wire        issue,
  input  wire [7:0]  opcode,
  // branch conditions from the datapath
  input  wire        acc_zero,
  input  wire        carry_flag,
  input  wire        addr_bit,
  input  wire        cmp_unequal,
  input  wire        dec_nonzero,
  // sequencing
  output wire        ready_r,
  output wire        busy_r,
  output wire        done_r,
  // decode results
  output reg  [7:0]  opcode_r,
  output reg  [1:0]  len_r,
  output reg  [4:0]  cycles_r,
  output reg  [3:0]  cond_r,
  output reg         taken_r,
  output reg         unknown_r,
  // operand selects
  output reg  [2:0]  wreg_sel_r,
  output reg         ptr_sel_r,
  // datapath actions
  output reg         ext_rd_r,
  output reg         ext_wr_r,
  output reg         wide_addr_r,
  output reg         code_fetch_r,
  output reg         stack_push_r,
  output reg         stack_pop_r,
  output reg         nibble_only_r,
  output reg         bit_clear_r
);

  wire [4:0] op5;
  wire [6:0] op7;
  wire [4:0] lo5;
  wire       issue_ok;

  reg  [1:0] d_len;
  reg  [4:0] d_nt;
  reg  [3:0] d_cond;
  reg        d_unk;
  reg        cond_true;
  wire       cond_branch;
  wire       redirect;
  wire [4:0] d_extra;
  wire [4:0] d_cycles;

  assign op5 = opcode[7:3];
  assign op7 = opcode[7:1];
  assign lo5 = opcode[4:0];

  // held off while the previous instruction still has cycles to run
  assign issue_ok = ce & issue & ready_r;

  // length and not-taken cycle count per opcode group
  always @*
  begin
    {d_len, d_nt} = {`MDB_L1, `MDB_C1};
    d_unk         = 1'b0;
    case (1'b1)
      (op5 == `MDB_P5_MOV_A_REG):   {d_len, d_nt} = {`MDB_L1, `MDB_C1};
      (opcode == `MDB_OP_MOV_A_DIR): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (op7 == `MDB_P7_MOV_A_IND):   {d_len, d_nt} = {`MDB_L1, `MDB_C2};
      (opcode == `MDB_OP_MOV_A_IMM): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (op5 == `MDB_P5_MOV_REG_A):   {d_len, d_nt} = {`MDB_L1, `MDB_C2};
      (op5 == `MDB_P5_MOV_REG_DIR): {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (op5 == `MDB_P5_MOV_REG_IMM): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_MOV_DIR_A): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (op5 == `MDB_P5_MOV_DIR_REG): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_MOV_DIR_DIR): {d_len, d_nt} = {`MDB_L3, `MDB_C3};
      (op7 == `MDB_P7_MOV_DIR_IND): {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_MOV_DIR_IMM): {d_len, d_nt} = {`MDB_L3, `MDB_C3};
      (op7 == `MDB_P7_MOV_IND_A):   {d_len, d_nt} = {`MDB_L1, `MDB_C2};
      (op7 == `MDB_P7_MOV_IND_DIR): {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (op7 == `MDB_P7_MOV_IND_IMM): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_MOV_DP_IMM): {d_len, d_nt} = {`MDB_L3, `MDB_C3};
      (opcode == `MDB_OP_CODE_DP):  {d_len, d_nt} = {`MDB_L1, `MDB_C7};
      (opcode == `MDB_OP_CODE_PC):  {d_len, d_nt} = {`MDB_L1, `MDB_C8};
      (op7 == `MDB_P7_XRD_IND):     {d_len, d_nt} = {`MDB_L1, `MDB_C5};
      (opcode == `MDB_OP_XRD_DP):   {d_len, d_nt} = {`MDB_L1, `MDB_C6};
      (op7 == `MDB_P7_XWR_IND):     {d_len, d_nt} = {`MDB_L1, `MDB_C4};
      (opcode == `MDB_OP_XWR_DP):   {d_len, d_nt} = {`MDB_L1, `MDB_C5};
      (opcode == `MDB_OP_PUSH):     {d_len, d_nt} = {`MDB_L2, `MDB_C5};
      (opcode == `MDB_OP_POP):      {d_len, d_nt} = {`MDB_L2, `MDB_C4};
      (op5 == `MDB_P5_XCH_REG):     {d_len, d_nt} = {`MDB_L1, `MDB_C3};
      (opcode == `MDB_OP_XCH_DIR):  {d_len, d_nt} = {`MDB_L2, `MDB_C4};
      (op7 == `MDB_P7_XCH_IND):     {d_len, d_nt} = {`MDB_L1, `MDB_C4};
      (op7 == `MDB_P7_XNIB):        {d_len, d_nt} = {`MDB_L1, `MDB_C4};
      (lo5 == `MDB_L5_ACALL):       {d_len, d_nt} = {`MDB_L2, `MDB_C7};
      (opcode == `MDB_OP_LCALL):    {d_len, d_nt} = {`MDB_L3, `MDB_C7};
      (opcode == `MDB_OP_RET):      {d_len, d_nt} = {`MDB_L1, `MDB_C8};
      (opcode == `MDB_OP_RETI):     {d_len, d_nt} = {`MDB_L1, `MDB_C8};
      (lo5 == `MDB_L5_AJMP):        {d_len, d_nt} = {`MDB_L2, `MDB_C4};
      (opcode == `MDB_OP_LJMP):     {d_len, d_nt} = {`MDB_L3, `MDB_C5};
      (opcode == `MDB_OP_RJMP):     {d_len, d_nt} = {`MDB_L2, `MDB_C4};
      (opcode == `MDB_OP_JMP_IND):  {d_len, d_nt} = {`MDB_L1, `MDB_C6};
      (opcode == `MDB_OP_JZ):       {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_JNZ):      {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_JC):       {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_JNC):      {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_JB):       {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (opcode == `MDB_OP_JNB):      {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (opcode == `MDB_OP_JTC):      {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (opcode == `MDB_OP_CBNE_DIR): {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (opcode == `MDB_OP_CBNE_IMM): {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (op5 == `MDB_P5_CBNE_REG):    {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (op7 == `MDB_P7_CBNE_IND):    {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (op5 == `MDB_P5_DBNZ_REG):    {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_DBNZ_DIR): {d_len, d_nt} = {`MDB_L3, `MDB_C4};
      (opcode == `MDB_OP_NOP):      {d_len, d_nt} = {`MDB_L1, `MDB_C1};
      (opcode == `MDB_OP_CLR_C):    {d_len, d_nt} = {`MDB_L1, `MDB_C1};
      (opcode == `MDB_OP_CLR_BIT):  {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_SETB_C):   {d_len, d_nt} = {`MDB_L1, `MDB_C1};
      (opcode == `MDB_OP_SETB_BIT): {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_CPL_C):    {d_len, d_nt} = {`MDB_L1, `MDB_C1};
      (opcode == `MDB_OP_CPL_BIT):  {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      (opcode == `MDB_OP_ANL_C):    {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_ANL_NC):   {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_ORL_C):    {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_ORL_NC):   {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_MOV_C_BIT): {d_len, d_nt} = {`MDB_L2, `MDB_C2};
      (opcode == `MDB_OP_MOV_BIT_C): {d_len, d_nt} = {`MDB_L2, `MDB_C3};
      default:                      d_unk = 1'b1;
    endcase
  end

  // branch condition kind per opcode
  always @*
  begin
    d_cond = `MDB_K_NONE;
    case (1'b1)
      (opcode == `MDB_OP_RJMP),
      (opcode == `MDB_OP_JMP_IND),
      (opcode == `MDB_OP_LJMP),
      (opcode == `MDB_OP_LCALL),
      (opcode == `MDB_OP_RET),
      (opcode == `MDB_OP_RETI),
      (lo5 == `MDB_L5_AJMP),
      (lo5 == `MDB_L5_ACALL):       d_cond = `MDB_K_ALWAYS;
      (opcode == `MDB_OP_JZ):       d_cond = `MDB_K_AZ;
      (opcode == `MDB_OP_JNZ):      d_cond = `MDB_K_ANZ;
      (opcode == `MDB_OP_JC):       d_cond = `MDB_K_C;
      (opcode == `MDB_OP_JNC):      d_cond = `MDB_K_NC;
      (opcode == `MDB_OP_JB),
      (opcode == `MDB_OP_JTC):      d_cond = `MDB_K_B;
      (opcode == `MDB_OP_JNB):      d_cond = `MDB_K_NB;
      (opcode == `MDB_OP_CBNE_DIR),
      (opcode == `MDB_OP_CBNE_IMM),
      (op5 == `MDB_P5_CBNE_REG),
      (op7 == `MDB_P7_CBNE_IND):    d_cond = `MDB_K_NE;
      (op5 == `MDB_P5_DBNZ_REG),
      (opcode == `MDB_OP_DBNZ_DIR): d_cond = `MDB_K_DNZ;
      default:                      d_cond = `MDB_K_NONE;
    endcase
  end

  // sample the datapath condition in the issue cycle
  always @*
  begin
    case (d_cond)
      `MDB_K_ALWAYS: cond_true = 1'b1;
      `MDB_K_AZ:     cond_true = acc_zero;
      `MDB_K_ANZ:    cond_true = ~acc_zero;
      `MDB_K_C:      cond_true = carry_flag;
      `MDB_K_NC:     cond_true = ~carry_flag;
      `MDB_K_B:      cond_true = addr_bit;
      `MDB_K_NB:     cond_true = ~addr_bit;
      `MDB_K_NE:     cond_true = cmp_unequal;
      `MDB_K_DNZ:    cond_true = dec_nonzero;
      default:       cond_true = 1'b0;
    endcase
  end

  // unconditional transfers are already costed in full; only tested ones add
  assign cond_branch = (d_cond != `MDB_K_NONE) & (d_cond != `MDB_K_ALWAYS);
  assign redirect    = cond_true;
  assign d_extra     = (cond_branch & redirect) ? `MDB_TAKEN_EXTRA : 5'h00;
  assign d_cycles    = d_nt + d_extra;

  // one machine cycle per ref_clk cycle
  mdb_cycle_cnt #(
    .W        (`MDB_CYC_W)
  ) u_cnt (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .load     (issue_ok),
    .load_val (d_cycles),
    .busy_r   (busy_r),
    .last_r   (done_r),
    .ready_r  (ready_r)
  );

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      opcode_r      <= 8'h00;
      len_r         <= 2'h0;
      cycles_r      <= 5'h00;
      cond_r        <= `MDB_K_NONE;
      taken_r       <= 1'b0;
      unknown_r     <= 1'b0;
      wreg_sel_r    <= 3'h0;
      ptr_sel_r     <= 1'b0;
      ext_rd_r      <= 1'b0;
      ext_wr_r      <= 1'b0;
      wide_addr_r   <= 1'b0;
      code_fetch_r  <= 1'b0;
      stack_push_r  <= 1'b0;
      stack_pop_r   <= 1'b0;
      nibble_only_r <= 1'b0;
      bit_clear_r   <= 1'b0;
    end
    else if (issue_ok)
    begin
      opcode_r      <= opcode;
      len_r         <= d_len;
      cycles_r      <= d_cycles;
      cond_r        <= d_cond;
      taken_r       <= redirect;
      unknown_r     <= d_unk;
      // working register in bits 2:0, indirect pointer in bit 0
      wreg_sel_r    <= opcode[2:0];
      ptr_sel_r     <= opcode[0];
      ext_rd_r      <= (op7 == `MDB_P7_XRD_IND) | (opcode == `MDB_OP_XRD_DP);
      ext_wr_r      <= (op7 == `MDB_P7_XWR_IND) | (opcode == `MDB_OP_XWR_DP);
      wide_addr_r   <= (opcode == `MDB_OP_XRD_DP) | (opcode == `MDB_OP_XWR_DP);
      code_fetch_r  <= (opcode == `MDB_OP_CODE_DP) | (opcode == `MDB_OP_CODE_PC);
      stack_push_r  <= (opcode == `MDB_OP_PUSH);
      stack_pop_r   <= (opcode == `MDB_OP_POP);
      nibble_only_r <= (op7 == `MDB_P7_XNIB);
      // clear happens only on the path where the bit was found set
      bit_clear_r   <= (opcode == `MDB_OP_JTC) & addr_bit;
    end
  end

endmodule // mdb_decode

// *** verification/mdb_decode_assertions.sv ***
// Purpose: concurrent checks on the decoder ports
// Assumes: one clock domain, synchronous active-high reset
// Notes:   cnt_r counts the machine cycles of the instruction in flight
module mdb_decode_assertions (
  // clock, reset, enable
  input wire       ref_clk,
  input wire       rst,
  input wire       ce,
  // issue and conditions
  input wire       issue,
  input wire [7:0] opcode,
  input wire       acc_zero,
  input wire       carry_flag,
  input wire       addr_bit,
  // results
  input wire       ready_r,
  input wire       busy_r,
  input wire       done_r,
  input wire [7:0] opcode_r,
  input wire [1:0] len_r,
  input wire [4:0] cycles_r,
  input wire [3:0] cond_r,
  input wire       taken_r,
  input wire       ext_rd_r,
  input wire       wide_addr_r,
  input wire       code_fetch_r,
  input wire       bit_clear_r
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  wire       acc_w = ce && issue && ready_r;
  reg  [4:0] cnt_r;

  // frozen with ce so a stretched instruction still counts its own cycles
  always @(posedge ref_clk)
  begin
    if (rst)
      cnt_r <= 5'h00;
    else if (acc_w)
      cnt_r <= 5'h01;
    else if (ce && busy_r)
      cnt_r <= cnt_r + 5'h01;
  end

  accept_starts_a: assert property (acc_w |=> busy_r && opcode_r == $past(opcode))
    else $error("accepted issue did not start");
  done_count_a: assert property (done_r |-> cnt_r == cycles_r)
    else $error("done in the wrong cycle");
  ready_done_a: assert property (busy_r |-> ready_r == done_r)
    else $error("ready and done differ while busy");
  done_pulse_a: assert property (done_r && ce && !acc_w |=> !busy_r && !done_r)
    else $error("instruction ran past done");
  ce_freeze_a: assert property (!ce |=> $stable(busy_r) && $stable(done_r) && $stable(opcode_r))
    else $error("state moved with ce low");
  reg_copy_a: assert property (acc_w && opcode[7:3] == 5'h1d |=>
    len_r == 2'h1 && cycles_r == 5'h01 && done_r)
    else $error("register copy timing wrong");
  code_fetch_a: assert property (acc_w && opcode == 8'h83 |=>
    code_fetch_r && cycles_r == 5'h08 ##7 done_r)
    else $error("code fetch timing wrong");
  ext_wide_a: assert property (acc_w && opcode == 8'he0 |=>
    ext_rd_r && wide_addr_r && cycles_r == 5'h06)
    else $error("wide external read wrong");
  zero_branch_a: assert property (acc_w && opcode == 8'h60 |=> cond_r == 4'h2 &&
    taken_r == $past(acc_zero) && cycles_r == ($past(acc_zero) ? 5'h05 : 5'h03))
    else $error("zero branch wrong");
  carry_branch_a: assert property (acc_w && opcode == 8'h40 && !carry_flag |=>
    !taken_r && cycles_r == 5'h02 ##1 done_r)
    else $error("carry branch not taken wrong");
  bit_clear_a: assert property (acc_w && opcode == 8'h10 |=>
    bit_clear_r == $past(addr_bit) && len_r == 2'h3)
    else $error("bit clear branch wrong");

  taken_c: cover property (acc_w && opcode == 8'h60 && acc_zero);
  back_c: cover property (acc_w && done_r);
  freeze_c: cover property (!ce && busy_r);
endmodule // mdb_decode_assertions

bind mdb_decode mdb_decode_assertions u_mdb_decode_assertions (
  .ref_clk(ref_clk), .rst(rst), .ce(ce), .issue(issue), .opcode(opcode),
  .acc_zero(acc_zero), .carry_flag(carry_flag), .addr_bit(addr_bit),
  .ready_r(ready_r), .busy_r(busy_r), .done_r(done_r), .opcode_r(opcode_r),
  .len_r(len_r), .cycles_r(cycles_r), .cond_r(cond_r), .taken_r(taken_r),
  .ext_rd_r(ext_rd_r), .wide_addr_r(wide_addr_r), .code_fetch_r(code_fetch_r),
  .bit_clear_r(bit_clear_r)
);

// *** verification/mdb_decode_tb.sv ***
// Purpose: directed bench for the move, branch and boolean decoder
// Assumes: inputs change at the falling edge; cnd is {acc_zero, carry, bit, unequal, nonzero}
// Notes:   act is {unknown, ext_rd, ext_wr, wide, code, push, pop, nibble, bit_clear}
module mdb_decode_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus
  logic       ref_clk    = 1'b0;
  logic       rst        = 1'b1;
  logic       ce         = 1'b1;
  logic       issue      = 1'b0;
  logic [7:0] opcode     = 8'h00;
  logic [4:0] cnd        = 5'h00;
  int         errors     = 0;
  int         num_checks = 0;
  // design outputs
  wire        ready_r, busy_r, done_r, taken_r, unknown_r, ptr_sel_r;
  wire        ext_rd_r, ext_wr_r, wide_addr_r, code_fetch_r;
  wire        stack_push_r, stack_pop_r, nibble_only_r, bit_clear_r;
  wire [7:0]  opcode_r;
  wire [1:0]  len_r;
  wire [4:0]  cycles_r;
  wire [3:0]  cond_r;
  wire [2:0]  wreg_sel_r;
  wire [8:0]  act = {unknown_r, ext_rd_r, ext_wr_r, wide_addr_r, code_fetch_r,
                     stack_push_r, stack_pop_r, nibble_only_r, bit_clear_r};

  mdb_decode u_mdb_decode (
    .ref_clk(ref_clk), .rst(rst), .ce(ce), .issue(issue), .opcode(opcode),
    .acc_zero(cnd[4]), .carry_flag(cnd[3]), .addr_bit(cnd[2]),
    .cmp_unequal(cnd[1]), .dec_nonzero(cnd[0]),
    .ready_r(ready_r), .busy_r(busy_r), .done_r(done_r), .opcode_r(opcode_r),
    .len_r(len_r), .cycles_r(cycles_r), .cond_r(cond_r), .taken_r(taken_r),
    .unknown_r(unknown_r), .wreg_sel_r(wreg_sel_r), .ptr_sel_r(ptr_sel_r),
    .ext_rd_r(ext_rd_r), .ext_wr_r(ext_wr_r), .wide_addr_r(wide_addr_r),
    .code_fetch_r(code_fetch_r), .stack_push_r(stack_push_r),
    .stack_pop_r(stack_pop_r), .nibble_only_r(nibble_only_r), .bit_clear_r(bit_clear_r)
  );

  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // called at the negedge of cycle 1; n is the cycle that shows done
  task automatic wait_done(output int n);
    n = 1;
    while (done_r !== 1'b1)
    begin
      @(negedge ref_clk);
      n++;
      if (n > 30)
      begin
        errors++;
        $display("mismatch done expected 1 seen timeout");
        tally_and_finish();
      end
    end
  endtask

  // conditions flip after issue: they must be latched at the accepting edge
  task automatic run(input logic [7:0] op, input logic [4:0] c, input logic [1:0] len,
                     input logic [4:0] cyc, input logic tk, input logic [8:0] a);
    int n;
    chk("ready", 16'h1, 16'(ready_r));
    issue  = 1'b1;
    opcode = op;
    cnd    = c;
    @(negedge ref_clk);
    issue = 1'b0;
    cnd   = ~c;
    wait_done(n);
    chk("len", 16'(len), 16'(len_r));
    chk("cycles", 16'(cyc), 16'(n));
    chk("cycles_r", 16'(cyc), 16'(cycles_r));
    chk("taken", 16'(tk), 16'(taken_r));
    chk("actions", 16'(a), 16'(act));
    chk("opcode", 16'(op), 16'(opcode_r));
    @(negedge ref_clk);
    chk("idle", 16'h0, 16'({busy_r, done_r}));
  endtask

  task automatic t_moves();
    run(8'he8, 5'h1f, 2'h1, 5'h01, 1'b0, 9'h000);
    run(8'hef, 5'h00, 2'h1, 5'h01, 1'b0, 9'h000);
    chk("wreg_sel", 16'h7, 16'(wreg_sel_r));
    run(8'he5, 5'h00, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'he7, 5'h00, 2'h1, 5'h02, 1'b0, 9'h000);
    chk("ptr_sel", 16'h1, 16'(ptr_sel_r));
    run(8'h74, 5'h00, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'hf8, 5'h00, 2'h1, 5'h02, 1'b0, 9'h000);
    run(8'hff, 5'h00, 2'h1, 5'h02, 1'b0, 9'h000);
    run(8'ha8, 5'h00, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'haf, 5'h00, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'h85, 5'h00, 2'h3, 5'h03, 1'b0, 9'h000);
    run(8'ha6, 5'h00, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'h90, 5'h00, 2'h3, 5'h03, 1'b0, 9'h000);
    run(8'h93, 5'h00, 2'h1, 5'h07, 1'b0, 9'h010);
    run(8'h83, 5'h00, 2'h1, 5'h08, 1'b0, 9'h010);
    run(8'he2, 5'h00, 2'h1, 5'h05, 1'b0, 9'h080);
    run(8'he3, 5'h00, 2'h1, 5'h05, 1'b0, 9'h080);
    run(8'he0, 5'h00, 2'h1, 5'h06, 1'b0, 9'h0a0);
    run(8'hf2, 5'h00, 2'h1, 5'h04, 1'b0, 9'h040);
    run(8'hf3, 5'h00, 2'h1, 5'h04, 1'b0, 9'h040);
    run(8'hf0, 5'h00, 2'h1, 5'h05, 1'b0, 9'h060);
    run(8'hc0, 5'h00, 2'h2, 5'h05, 1'b0, 9'h008);
    run(8'hd0, 5'h00, 2'h2, 5'h04, 1'b0, 9'h004);
    run(8'hd6, 5'h00, 2'h1, 5'h04, 1'b0, 9'h002);
    run(8'hd7, 5'h00, 2'h1, 5'h04, 1'b0, 9'h002);
    $display("test moves done");
  endtask

  // taken: only the tested condition high, or only it low for 0x70, 0x50, 0x30; not taken: the reverse
  task automatic t_branches();
    run(8'h80, 5'h00, 2'h2, 5'h04, 1'b1, 9'h000);
    run(8'h73, 5'h00, 2'h1, 5'h06, 1'b1, 9'h000);
    run(8'h60, 5'h10, 2'h2, 5'h05, 1'b1, 9'h000);
    run(8'h60, 5'h0f, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'h70, 5'h0f, 2'h2, 5'h05, 1'b1, 9'h000);
    run(8'h70, 5'h10, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'h40, 5'h08, 2'h2, 5'h04, 1'b1, 9'h000);
    run(8'h40, 5'h17, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'h50, 5'h17, 2'h2, 5'h04, 1'b1, 9'h000);
    run(8'h50, 5'h08, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'h20, 5'h04, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'h20, 5'h1b, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'h30, 5'h1b, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'h30, 5'h04, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'h10, 5'h04, 2'h3, 5'h06, 1'b1, 9'h001);
    run(8'h10, 5'h1b, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'hb5, 5'h02, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'hb4, 5'h1d, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'hb8, 5'h02, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'hbf, 5'h1d, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'hb6, 5'h02, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'hb7, 5'h1d, 2'h3, 5'h04, 1'b0, 9'h000);
    chk("cond", 16'h8, 16'(cond_r));
    run(8'hd8, 5'h01, 2'h2, 5'h05, 1'b1, 9'h000);
    run(8'hdf, 5'h1e, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'hd5, 5'h01, 2'h3, 5'h06, 1'b1, 9'h000);
    run(8'hd5, 5'h1e, 2'h3, 5'h04, 1'b0, 9'h000);
    run(8'h82, 5'h1f, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'hb0, 5'h1f, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'h72, 5'h1f, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'ha0, 5'h1f, 2'h2, 5'h02, 1'b0, 9'h000);
    run(8'h92, 5'h1f, 2'h2, 5'h03, 1'b0, 9'h000);
    run(8'ha2, 5'h1f, 2'h2, 5'h02, 1'b0, 9'h000);
    $display("test branches done");
  endtask

  // issue held high: a refused opcode mid-instruction, then one taken in the done cycle
  task automatic t_back();
    issue  = 1'b1;
    opcode = 8'h74;
    @(negedge ref_clk);
    chk("ready", 16'h0, 16'(ready_r));
    opcode = 8'h83;
    @(negedge ref_clk);
    chk("refused", 16'h74, 16'(opcode_r));
    chk("done", 16'h1, 16'(done_r));
    opcode = 8'he8;
    @(negedge ref_clk);
    issue = 1'b0;
    chk("back", 16'he8, 16'(opcode_r));
    chk("done_busy", 16'h3, 16'({busy_r, done_r}));
    @(negedge ref_clk);
    $display("test back to back done");
  endtask

  task automatic t_ce();
    int n;
    issue  = 1'b1;
    opcode = 8'hc0;
    @(negedge ref_clk);
    issue = 1'b0;
    @(negedge ref_clk);
    ce = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk("frozen", 16'h2, 16'({busy_r, done_r}));
    ce = 1'b1;
    wait_done(n);
    // five cycles, one already run before the freeze
    chk("ce_stretch", 16'h4, 16'(n));
    @(negedge ref_clk);
    $display("test clock enable done");
  endtask

  task automatic t_reset();
    run(8'h28, 5'h1f, 2'h1, 5'h01, 1'b0, 9'h100);
    issue  = 1'b1;
    opcode = 8'h83;
    @(negedge ref_clk);
    issue = 1'b0;
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    chk("rst_seq", 16'h4, 16'({ready_r, busy_r, done_r}));
    chk("rst_decode", 16'h0, 16'({len_r, cycles_r, cond_r, taken_r}));
    run(8'he8, 5'h00, 2'h1, 5'h01, 1'b0, 9'h000);
    $display("test reset done");
  endtask

  initial
  begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    t_moves();
    t_branches();
    t_back();
    t_ce();
    t_reset();
    tally_and_finish();
  end
endmodule // mdb_decode_tb
